//--- core/adcsq_control.sv
// Sequence control for the converter: AHB-Lite registers, sequencer and interrupt
`include "adcsq_regs.svh"

module adcsq_control #(
    parameter int CONV_DIV = 6
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Start events
    input wire logic extTrigger,
    input wire logic timerCompare,
    // Analog front end
    input wire logic [11:0] sampleIn,
    output adcsq_pkg::adcsq_fe_type frontEnd,
    // Events
    output logic dmaTrigger,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic wrPend;
    logic rdPend;
    logic [7:0] wrIdx;
    logic [7:0] rdIdx;
    wire addrPhase = hsel & htrans[1] & hready;
    wire [7:0] reqIdx = haddr[9:2];
    wire mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    wire [7:0] reqIdxMapped = mapped ? reqIdx : 8'h00;

    wire wrCtl1 = wrPend & (wrIdx == `ADCSQ_IDX_CTL1);
    wire wrSeq = wrPend & (wrIdx == `ADCSQ_IDX_SEQ);
    wire wrMask = wrPend & (wrIdx == `ADCSQ_IDX_IMASK);
    wire rdHigh = rdPend & (rdIdx == `ADCSQ_IDX_RESHI);
    wire rdStat = rdPend & (rdIdx == `ADCSQ_IDX_ISTAT);

    // Data phase flags, one cycle after the address is taken
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
        end else if (clkEn) begin
            wrPend <= addrPhase & hwrite;
            rdPend <= addrPhase & ~hwrite;
        end
    end

    // Register index held through the data phase
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrIdx <= 8'h00;
            rdIdx <= 8'h00;
        end else if (clkEn && addrPhase) begin
            wrIdx <= reqIdxMapped;
            rdIdx <= reqIdxMapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [3:0] ctl1Low;
    logic [1:0] startSel;
    logic stBit;
    logic eoc;
    logic [3:0] seqCfg;
    logic [3:0] seqEnd;
    logic [3:0] chanShown;
    logic [11:0] result;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    adcsq_pkg::adcsq_state_type state;
    logic convDone;
    logic seqDone;
    logic convEnd;
    logic lastConv;

    wire idle = (state == adcsq_pkg::ADCSQ_IDLE);
    wire [1:0] wrStartSel = hwdata[`ADCSQ_START_EVENT_SELECT_HI:`ADCSQ_START_EVENT_SELECT_LO];
    wire stSet = wrCtl1 & hwdata[`ADCSQ_ST_BIT] & idle & (wrStartSel == `ADCSQ_START_SW);
    wire [1:0] events = {seqDone, convDone};
    wire seqFinish = convEnd & lastConv;
    wire [3:0] wrCfg = hwdata[`ADCSQ_CFG_HI:`ADCSQ_CFG_LO];
    wire [3:0] wrEnd = hwdata[`ADCSQ_CH_HI:`ADCSQ_CH_LO];

    // Hardware sets win over software clears
    // Start bit drops on the ending edge, so idle never restarts
    wire next_stBit = stSet | (stBit & ~seqFinish);
    wire next_eoc = convDone | (eoc & ~rdHigh);
    wire [1:0] next_irqStat = events | (irqStat & ~{2{rdStat}});
    // Channel taken before it steps on
    wire [3:0] next_chanShown = convEnd ? frontEnd.channel :
                                wrSeq ? wrEnd : chanShown;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctl1Low <= `ADCSQ_CTL1_RST;
            startSel <= `ADCSQ_START_EVENT_SELECT_RST;
            seqCfg <= `ADCSQ_SEQCFG_RST;
            seqEnd <= `ADCSQ_SEQEND_RST;
            irqMask <= 2'h0;
        end else if (clkEn) begin
            if (wrCtl1) begin
                ctl1Low <= hwdata[3:0];
                startSel <= wrStartSel;
            end
            if (wrSeq) begin
                seqCfg <= wrCfg;
                seqEnd <= wrEnd;
            end
            if (wrMask) begin
                irqMask <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stBit <= 1'b0;
            eoc <= 1'b0;
            irqStat <= 2'h0;
            chanShown <= `ADCSQ_SEQEND_RST;
        end else if (clkEn) begin
            stBit <= next_stBit;
            eoc <= next_eoc;
            irqStat <= next_irqStat;
            chanShown <= next_chanShown;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, one wait state per read

    wire [7:0] ctl1Read = {eoc, stBit, startSel, ctl1Low};
    wire [7:0] seqRead = {seqCfg, chanShown};
    wire [7:0] resLoRead = {result[3:0], 4'h0};
    wire [7:0] resHiRead = result[11:4];
    wire [7:0] rdMux = (rdIdx == `ADCSQ_IDX_CTL1) ? ctl1Read :
                       (rdIdx == `ADCSQ_IDX_SEQ) ? seqRead :
                       (rdIdx == `ADCSQ_IDX_RESLO) ? resLoRead :
                       (rdIdx == `ADCSQ_IDX_RESHI) ? resHiRead :
                       (rdIdx == `ADCSQ_IDX_ISTAT) ? {6'h00, irqStat} :
                       (rdIdx == `ADCSQ_IDX_IMASK) ? {6'h00, irqMask} : 8'h00;

    // Ready drops for the single read wait cycle; response always OKAY
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clkEn) begin
            hreadyout <= ~(addrPhase & ~hwrite);
        end
    end

    // Read data stands until the next read
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (clkEn && rdPend) begin
            hrdata <= {24'h000000, rdMux};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start event and sequence bounds

    logic extPrev;
    wire extRise = extTrigger & ~extPrev;
    wire startReq = (startSel == `ADCSQ_START_PIN) ? extRise :
                    (startSel == `ADCSQ_START_FREE) ? 1'b1 :
                    (startSel == `ADCSQ_START_TIMER) ? timerCompare : stBit;
    wire startNow = idle & startReq;

    wire isSingle = (seqEnd >= `ADCSQ_CH_FIRST_SINGLE);
    wire isDiff = (seqEnd >= `ADCSQ_CH_FIRST_DIFF) & ~isSingle;
    wire [3:0] firstCh = isSingle ? seqEnd :
                         isDiff ? `ADCSQ_CH_FIRST_DIFF : `ADCSQ_CH_FIRST_SE;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion timing

    logic [3:0] actEnd;
    logic [11:0] periodCnt;
    logic [7:0] divCnt;
    wire [1:0] decim = frontEnd.decimation;
    wire [11:0] decRate = (decim == 2'h0) ? `ADCSQ_DEC64 :
                          (decim == 2'h1) ? `ADCSQ_DEC128 :
                          (decim == 2'h2) ? `ADCSQ_DEC256 : `ADCSQ_DEC512;
    wire [11:0] lastPeriod = decRate + `ADCSQ_SETTLE - 12'h001;
    wire [11:0] resMask = (decim == 2'h0) ? `ADCSQ_MASK7 :
                          (decim == 2'h1) ? `ADCSQ_MASK9 :
                          (decim == 2'h2) ? `ADCSQ_MASK10 : `ADCSQ_MASK12;
    wire divWrap = (divCnt == 8'(CONV_DIV - 1));
    assign convEnd = ~idle & divWrap & (periodCnt == lastPeriod);
    assign lastConv = (frontEnd.channel == actEnd);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Trigger pin history for the edge detector
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            extPrev <= 1'b0;
        end else if (clkEn) begin
            extPrev <= extTrigger;
        end
    end

    // Converter clock divider and period count of one conversion
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divCnt <= 8'h00;
            periodCnt <= 12'h000;
        end else if (clkEn) begin
            if (idle || convEnd) begin
                divCnt <= 8'h00;
                periodCnt <= 12'h000;
            end else if (divWrap) begin
                divCnt <= 8'h00;
                periodCnt <= periodCnt + 12'h001;
            end else begin
                divCnt <= divCnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= adcsq_pkg::ADCSQ_IDLE;
            frontEnd <= '0;
            actEnd <= 4'h0;
        end else if (clkEn) begin
            case (state)
                adcsq_pkg::ADCSQ_IDLE: begin
                    if (startNow) begin
                        state <= adcsq_pkg::ADCSQ_CONV;
                        frontEnd.active <= 1'b1;
                        frontEnd.reference <= seqCfg[3:2];
                        frontEnd.decimation <= seqCfg[1:0];
                        frontEnd.channel <= firstCh;
                        actEnd <= seqEnd;
                    end
                end
                adcsq_pkg::ADCSQ_CONV: begin
                    if (seqFinish) begin
                        state <= adcsq_pkg::ADCSQ_IDLE;
                        frontEnd.active <= 1'b0;
                    end else if (convEnd) begin
                        frontEnd.channel <= frontEnd.channel + 4'h1;
                    end
                end
                default: begin
                    state <= adcsq_pkg::ADCSQ_IDLE;
                    frontEnd.active <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result capture and events

    // Front end result taken on the ending edge, cut to the resolution
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            result <= 12'h000;
        end else if (clkEn && convEnd) begin
            result <= sampleIn & resMask;
        end
    end

    // Done flags and DMA trigger follow the ending edge by one cycle, irq by two
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            convDone <= 1'b0;
            seqDone <= 1'b0;
            dmaTrigger <= 1'b0;
            irq <= 1'b0;
        end else if (clkEn) begin
            convDone <= convEnd;
            seqDone <= seqFinish;
            dmaTrigger <= convEnd;
            irq <= |(next_irqStat & irqMask);
        end
    end

endmodule // adcsq_control

//--- core/adcsq_regs.svh
// Register map, field positions, reset values and timing constants of the sequence control
// Function
// - Two-bit reference select: internal 1.25V, external pin, supply, external pair
// - Two-bit decimation select gives rates 64, 128, 256 or 512
// - Decimation rate fixes resolution 7, 9, 10 or 12 bits and duration
// - Four-bit end channel: codes 0-7 single-ended, 8-11 differential pairs
// - Single-ended sweep converts input zero up to programmed input
// - Differential sweep converts first pair up to programmed pair
// - Codes 12 and up do one conversion of ground, reference, sensor, supply/3
// - Reading end channel field returns the last converted or last written channel, whichever is newer
// - A DMA trigger pulses for every new sample, sequence or single
// - Result left-justified over high and low bytes, decimation sets valid bits
// - Sequence starts on pin trigger, free-run, timer compare or software bit
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// Register indices; byte address is four times the index
`define ADCSQ_IDX_CTL1 8'hb4
`define ADCSQ_IDX_SEQ 8'hb5
`define ADCSQ_IDX_RESLO 8'hba
`define ADCSQ_IDX_RESHI 8'hbb
`define ADCSQ_IDX_ISTAT 8'hc0
`define ADCSQ_IDX_IMASK 8'hc1

// Reset values
`define ADCSQ_CTL1_RST 4'h3
`define ADCSQ_START_EVENT_SELECT_RST 2'h3
`define ADCSQ_SEQCFG_RST 4'h1
`define ADCSQ_SEQEND_RST 4'h0

// Field positions
`define ADCSQ_EOC_BIT 7
`define ADCSQ_ST_BIT 6
`define ADCSQ_START_EVENT_SELECT_HI 5
`define ADCSQ_START_EVENT_SELECT_LO 4
`define ADCSQ_CFG_HI 7
`define ADCSQ_CFG_LO 4
`define ADCSQ_CH_HI 3
`define ADCSQ_CH_LO 0

// Start event codes
`define ADCSQ_START_PIN 2'h0
`define ADCSQ_START_FREE 2'h1
`define ADCSQ_START_TIMER 2'h2
`define ADCSQ_START_SW 2'h3

// Channel code boundaries
`define ADCSQ_CH_FIRST_SE 4'h0
`define ADCSQ_CH_FIRST_DIFF 4'h8
`define ADCSQ_CH_FIRST_SINGLE 4'hc

// Decimation rates in converter clock periods, plus settle time
`define ADCSQ_DEC64 12'h040
`define ADCSQ_DEC128 12'h080
`define ADCSQ_DEC256 12'h100
`define ADCSQ_DEC512 12'h200
`define ADCSQ_SETTLE 12'h010

// Left-justified resolution masks: 7, 9, 10 and 12 bits
`define ADCSQ_MASK7 12'hfe0
`define ADCSQ_MASK9 12'hff8
`define ADCSQ_MASK10 12'hffc
`define ADCSQ_MASK12 12'hfff

`endif

//--- core/adcsq_pkg.sv
// Types shared by the sequence control
package adcsq_pkg;
    typedef enum logic [0:0] {
        ADCSQ_IDLE = 1'b0,
        ADCSQ_CONV = 1'b1
    } adcsq_state_type;

    // Settings presented to the analog front end
    typedef struct packed {
        logic active;
        logic [1:0] reference;
        logic [1:0] decimation;
        logic [3:0] channel;
    } adcsq_fe_type;
endpackage

//--- bench/adcsq_fe_model.sv
// Behavioural analog front end: result encodes the channel being converted
module adcsq_fe_model (
    // Clock
    input wire logic clk_sys,
    // Settings in, result out
    input wire adcsq_pkg::adcsq_fe_type frontEnd,
    output logic [11:0] sampleIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] idleNoise = 12'h5a5;
    // Idle output toggles so a stale capture never looks valid
    always @(posedge clk_sys) idleNoise <= ~idleNoise;
    assign sampleIn = frontEnd.active ?
        {frontEnd.channel, ~frontEnd.channel, frontEnd.channel} : idleNoise;
endmodule // adcsq_fe_model

//--- bench/adcsq_control_props.sv
// Port assertions for the sequence control
module adcsq_control_props #(
    parameter int CONV_DIV = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // Front end and events
    input wire adcsq_pkg::adcsq_fe_type frontEnd,
    input wire logic dmaTrigger
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [11:0] cnt;
    logic [3:0] prevCh;
    logic [1:0] prevDec;
    logic prevAct;
    logic [15:0] convLen;
    logic taken;
    assign taken = hsel && htrans[1] && hready;
    assign convLen = ((16'h0040 << prevDec) + 16'h0010) * 16'(CONV_DIV);
    // Cycles spent on the current channel
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 12'h000;
            prevCh <= 4'h0;
            prevDec <= 2'h0;
            prevAct <= 1'h0;
        end else begin
            cnt <= (frontEnd.active && prevAct && frontEnd.channel == prevCh) ?
                cnt + 12'h001 : 12'h001;
            prevCh <= frontEnd.channel;
            prevDec <= frontEnd.decimation;
            prevAct <= frontEnd.active;
        end
    end
    chk_dma_pulse: assert property (dmaTrigger |=> !dmaTrigger)
        else $error("dma trigger longer than one cycle");
    chk_dma_cause: assert property (dmaTrigger |-> $past(frontEnd.active, 2))
        else $error("dma trigger without a conversion");
    chk_chan_step: assert property (frontEnd.active && prevAct &&
        frontEnd.channel != prevCh |-> frontEnd.channel == prevCh + 4'h1)
        else $error("channel did not advance by one");
    chk_single_hold: assert property (frontEnd.active && prevAct && prevCh >= 4'hc
        |-> frontEnd.channel == prevCh)
        else $error("single conversion changed channel");
    chk_conv_length: assert property (prevAct &&
        (!frontEnd.active || frontEnd.channel != prevCh) |-> {4'h0, cnt} == convLen)
        else $error("conversion length wrong");
    chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write inserted a wait");
    chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    chk_rdata_upper: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule // adcsq_control_props
bind adcsq_control adcsq_control_props #(.CONV_DIV(CONV_DIV)) i_adcsq_control_props (
    .clk_sys, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .frontEnd, .dmaTrigger);

//--- bench/adcsq_control_tb.sv
// Testbench for the sequence control
`include "adcsq_regs.svh"
module adcsq_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic extTrigger = 1'h0, timerCompare = 1'h0, hreadyout, hresp, dmaTrigger, irq;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [11:0] sampleIn, res;
    adcsq_pkg::adcsq_fe_type frontEnd;
    wire logic hready;
    int n_mismatch = 0, samples_checked = 0, nDma = 0;
    logic [7:0] cfg[6] = '{8'h03, 8'h5b, 8'hac, 8'hff, 8'h0d, 8'h0e};
    logic [11:0] msk[4] = '{12'hfe0, 12'hff8, 12'hffc, 12'hfff};
    logic [3:0] ch, first;
    int nConv;
    assign hready = hreadyout;
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (dmaTrigger === 1'h1) nDma++;
    adcsq_control i_adcsq_control (.clk_sys, .nrst, .clkEn(1'h1), .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .extTrigger,
        .timerCompare, .sampleIn, .frontEnd, .dmaTrigger, .irq);
    adcsq_fe_model i_adcsq_fe_model (.clk_sys, .frontEnd, .sampleIn);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d,
        output logic [31:0] r);
        hsel <= 1'h1;
        haddr <= {22'h0, i, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk_sys); while (hready !== 1'h1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        xfer(i, 1'h1, d, r);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] r;
        xfer(i, 1'h0, 8'h00, r);
        chk(r, {24'h0, e});
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic waitIdle;
        int k;
        k = 0;
        while (frontEnd.active !== 1'h0 && k < 20000) begin
            @(posedge clk_sys);
            k++;
        end
        chk({31'h0, frontEnd.active}, 32'h0);
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1500000;
        n_mismatch++;
        final_report();
    end
    initial begin
        cyc(20);
        nrst <= 1'h1;
        cyc(1);
        rdc(`ADCSQ_IDX_CTL1, 8'h33);
        rdc(`ADCSQ_IDX_SEQ, 8'h10);
        rdc(`ADCSQ_IDX_RESHI, 8'h00);
        rdc(`ADCSQ_IDX_ISTAT, 8'h00);
        rdc(8'h10, 8'h00);
        rdc(`ADCSQ_IDX_IMASK, 8'h00);
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            ch = cfg[i][3:0];
            first = ch < 4'h8 ? 4'h0 : ch < 4'hc ? 4'h8 : ch;
            nConv = ch < 4'h8 ? ch + 1 : ch < 4'hc ? ch - 7 : 1;
            wr(`ADCSQ_IDX_IMASK, i == 0 ? 8'h00 : 8'h03);
            wr(`ADCSQ_IDX_SEQ, cfg[i]);
            nDma = 0;
            wr(`ADCSQ_IDX_CTL1, 8'h73);
            cyc(3);
            chk(32'(frontEnd), {23'h0, 1'h1, cfg[i][7:4], first});
            if (i == 0) begin
                cyc(600);
                rdc(`ADCSQ_IDX_SEQ, 8'h00);
            end
            waitIdle();
            cyc(3);
            chk(nDma, nConv);
            chk({31'h0, irq}, {31'h0, i != 0});
            rdc(`ADCSQ_IDX_SEQ, cfg[i]);
            rdc(`ADCSQ_IDX_CTL1, 8'hb3);
            res = {ch, ~ch, ch} & msk[cfg[i][5:4]];
            rdc(`ADCSQ_IDX_RESHI, res[11:4]);
            rdc(`ADCSQ_IDX_RESLO, {res[3:0], 4'h0});
            rdc(`ADCSQ_IDX_CTL1, 8'h33);
            rdc(`ADCSQ_IDX_ISTAT, 8'h03);
            chk({31'h0, irq}, 32'h0);
        end
        $display("Test sequences done");
        wr(`ADCSQ_IDX_SEQ, 8'h0c);
        wr(`ADCSQ_IDX_CTL1, 8'h03);
        timerCompare <= 1'h1;
        cyc(1);
        timerCompare <= 1'h0;
        cyc(3);
        chk({31'h0, frontEnd.active}, 32'h0);
        extTrigger <= 1'h1;
        cyc(4);
        chk({31'h0, frontEnd.active}, 32'h1);
        waitIdle();
        wr(`ADCSQ_IDX_CTL1, 8'h23);
        cyc(3);
        chk({31'h0, frontEnd.active}, 32'h0);
        timerCompare <= 1'h1;
        cyc(1);
        timerCompare <= 1'h0;
        cyc(3);
        chk({31'h0, frontEnd.active}, 32'h1);
        waitIdle();
        wr(`ADCSQ_IDX_CTL1, 8'h13);
        waitIdle();
        cyc(3);
        chk({31'h0, frontEnd.active}, 32'h1);
        wr(`ADCSQ_IDX_CTL1, 8'h33);
        waitIdle();
        cyc(3);
        chk({31'h0, frontEnd.active}, 32'h0);
        $display("Test start events done");
        final_report();
    end
endmodule // adcsq_control_tb
